// File: hw/atc_pkg.sv
package atc_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_TRIM_UPPER = 12'h608;
	localparam logic [11:0] OFS_TRIM_GROUP5 = 12'h61d;
	localparam logic [11:0] OFS_SYNC_REF = 12'h70a;
	localparam logic [11:0] OFS_DC_LEVEL = 12'h71a;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int TRIM_UPPER_LSB = 6;
	localparam int TRIM_G5_HI_BIT = 7;
	localparam int TRIM_G5_LO_BIT = 1;
	localparam int SYNC_PDN_BIT = 0;
	localparam int DC_LEVEL_LSB = 1;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [1:0] RST_TRIM_UPPER = 2'h0;
	localparam logic [1:0] RST_TRIM_G5 = 2'h0;
	localparam logic RST_SYNC_PDN = 1'h0;
	localparam logic [2:0] RST_DC_LEVEL = 3'h0;
	// ------------------------------------------------------------
	// Output code equation
	// ------------------------------------------------------------
	localparam logic [11:0] DC_CODE_STEP = 12'h170;
	localparam logic [11:0] DC_CODE_BASE = 12'h2e9;
endpackage

// File: hw/atc_regs.sv
// What this block does
// (RULE1) Bits 7-6 of 0x608 are a read/write trim field.
// (RULE2) Above 100 MHz software sets all trim bits, incl. 0x61d bits 7, 1.
// (RULE3) Bit 0 of 0x70a powers down sync reference buffer; resets to 0.
// (RULE4) Software sets the power-down bit when sync reference pins are unused.
// (RULE5) Bits 3-1 of 0x71a inject one DC level into all channels.
// (RULE6) Injected code is 368 times field value plus 745.
// (RULE7) Software writes zero to reserved write-only bits.
//
// Implementation choice: strobed register access.
module atc_regs (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic o_hf_trim_enable,
	output logic [3:0] o_hf_trim_bits,
	output logic o_sync_ref_buffer_powerdown,
	output logic o_dc_level_injection_active,
	output logic [2:0] o_dc_level_injection,
	output logic [11:0] o_dc_level_code
);
	logic [1:0] trim_upper_q;
	logic [1:0] trim_g5_q;
	logic sync_pdn_q;
	logic [2:0] dc_level_q;
	logic [7:0] rdata_d;
	logic [11:0] code_d;

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	// Reserved bits are not stored; they always read back zero
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			trim_upper_q <= atc_pkg::RST_TRIM_UPPER;
			trim_g5_q <= atc_pkg::RST_TRIM_G5;
		end else if (i_wr && i_addr == atc_pkg::OFS_TRIM_UPPER) begin
			trim_upper_q <= i_wdata[atc_pkg::TRIM_UPPER_LSB +: 2]; // RULE1
		end else if (i_wr && i_addr == atc_pkg::OFS_TRIM_GROUP5) begin
			trim_g5_q <= {i_wdata[atc_pkg::TRIM_G5_HI_BIT],
				i_wdata[atc_pkg::TRIM_G5_LO_BIT]};
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			sync_pdn_q <= atc_pkg::RST_SYNC_PDN; // RULE3
		end else if (i_wr && i_addr == atc_pkg::OFS_SYNC_REF) begin
			sync_pdn_q <= i_wdata[atc_pkg::SYNC_PDN_BIT]; // RULE3
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			dc_level_q <= atc_pkg::RST_DC_LEVEL;
		end else if (i_wr && i_addr == atc_pkg::OFS_DC_LEVEL) begin
			dc_level_q <= i_wdata[atc_pkg::DC_LEVEL_LSB +: 3]; // RULE5
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		rdata_d = 8'h00;
		case (i_addr)
			atc_pkg::OFS_TRIM_UPPER: begin
				rdata_d[atc_pkg::TRIM_UPPER_LSB +: 2] = trim_upper_q; // RULE1
			end
			atc_pkg::OFS_TRIM_GROUP5: begin
				rdata_d[atc_pkg::TRIM_G5_HI_BIT] = trim_g5_q[1];
				rdata_d[atc_pkg::TRIM_G5_LO_BIT] = trim_g5_q[0];
			end
			atc_pkg::OFS_SYNC_REF: begin
				rdata_d[atc_pkg::SYNC_PDN_BIT] = sync_pdn_q;
			end
			atc_pkg::OFS_DC_LEVEL: begin
				rdata_d[atc_pkg::DC_LEVEL_LSB +: 3] = dc_level_q;
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// Data only in the cycle after the strobe; zero otherwise
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rdata_d : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Control outputs
	// ------------------------------------------------------------
	// 368*v+745 fits 12 bits for v up to 7 (max 3321)
	function automatic logic [11:0] dc_code_mul(input logic [2:0] v);
		dc_code_mul = 12'(atc_pkg::DC_CODE_STEP * {9'h000, v});
	endfunction

	assign code_d = dc_code_mul(dc_level_q) + atc_pkg::DC_CODE_BASE;

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hf_trim_bits <= 4'h0;
			o_hf_trim_enable <= 1'b0;
			o_sync_ref_buffer_powerdown <= 1'b0;
			o_dc_level_injection <= 3'h0;
			o_dc_level_injection_active <= 1'b0;
			// Field resets to 0, so the code starts at the base level
			o_dc_level_code <= atc_pkg::DC_CODE_BASE;
		end else begin
			o_hf_trim_bits <= {trim_upper_q, trim_g5_q};
			// Trim only takes effect once software has set every bit
			o_hf_trim_enable <= &{trim_upper_q, trim_g5_q}; // RULE2
			o_sync_ref_buffer_powerdown <= sync_pdn_q; // RULE3
			o_dc_level_injection <= dc_level_q; // RULE5
			o_dc_level_injection_active <= dc_level_q != 3'h0;
			o_dc_level_code <= code_d; // RULE6
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Control outputs lag a write by two edges: register, then output flop
	AST_SYNC_PDN_WRITE: assert property ( // RULE3
		@(posedge i_ref_clk) disable iff (i_rst)
		i_wr && i_addr == atc_pkg::OFS_SYNC_REF |-> ##2
		o_sync_ref_buffer_powerdown == $past(i_wdata[0], 2))
		else $error("sync ref power-down not following write");

	AST_DC_LEVEL_WRITE: assert property ( // RULE5
		@(posedge i_ref_clk) disable iff (i_rst)
		i_wr && i_addr == atc_pkg::OFS_DC_LEVEL |-> ##2
		o_dc_level_injection == $past(i_wdata[3:1], 2))
		else $error("dc level not following write");

	AST_DC_CODE: assert property ( // RULE6
		@(posedge i_ref_clk) disable iff (i_rst)
		o_dc_level_code == 12'(368 * o_dc_level_injection + 745))
		else $error("dc level code wrong");

	AST_DC_ACTIVE: assert property ( // RULE5
		@(posedge i_ref_clk) disable iff (i_rst)
		o_dc_level_injection_active == (o_dc_level_injection != 3'h0))
		else $error("dc level active flag wrong");

	AST_TRIM_G5_WRITE: assert property ( // RULE2
		@(posedge i_ref_clk) disable iff (i_rst)
		i_wr && i_addr == atc_pkg::OFS_TRIM_GROUP5 |-> ##2
		o_hf_trim_bits[1:0] == {$past(i_wdata[7], 2), $past(i_wdata[1], 2)})
		else $error("trim group bits not following write");

	AST_TRIM_ENABLE: assert property ( // RULE2
		@(posedge i_ref_clk) disable iff (i_rst)
		o_hf_trim_enable == (o_hf_trim_bits == 4'hf))
		else $error("trim enable mismatch");

	// ------------------------------------------------------------
	// Read checks
	// ------------------------------------------------------------
	AST_TRIM_READBACK: assert property ( // RULE1
		@(posedge i_ref_clk) disable iff (i_rst)
		i_wr && i_addr == atc_pkg::OFS_TRIM_UPPER ##1
		i_rd && i_addr == atc_pkg::OFS_TRIM_UPPER |=>
		o_rdata == ($past(i_wdata, 2) & 8'hc0))
		else $error("trim upper readback wrong");

	// Reserved bits never read back, whatever software wrote
	AST_TRIM_RESERVED: assert property ( // RULE1
		@(posedge i_ref_clk) disable iff (i_rst)
		i_rd && i_addr == atc_pkg::OFS_TRIM_UPPER |=>
		o_rdata[5:0] == 6'h00)
		else $error("trim upper reserved bits read nonzero");

	AST_PDN_RESERVED: assert property ( // RULE3
		@(posedge i_ref_clk) disable iff (i_rst)
		i_rd && i_addr == atc_pkg::OFS_SYNC_REF |=>
		o_rdata[7:1] == 7'h00)
		else $error("sync ref reserved bits read nonzero");

	AST_DC_RESERVED: assert property ( // RULE5
		@(posedge i_ref_clk) disable iff (i_rst)
		i_rd && i_addr == atc_pkg::OFS_DC_LEVEL |=>
		o_rdata[7:4] == 4'h0 && o_rdata[0] == 1'b0)
		else $error("dc level reserved bits read nonzero");

	AST_UNMAPPED_ZERO: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		i_rd && i_addr != atc_pkg::OFS_TRIM_UPPER &&
		i_addr != atc_pkg::OFS_TRIM_GROUP5 &&
		i_addr != atc_pkg::OFS_SYNC_REF &&
		i_addr != atc_pkg::OFS_DC_LEVEL |=> o_rdata == 8'h00)
		else $error("unmapped address read nonzero");

	AST_IDLE_RDATA: assert property (
		@(posedge i_ref_clk) disable iff (i_rst)
		!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside read cycle");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	COV_TRIM_ON: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(o_hf_trim_enable));
	COV_PDN: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(o_sync_ref_buffer_powerdown));
	COV_DC_MAX: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		o_dc_level_injection == 3'h7);
	COV_READBACK: cover property (@(posedge i_ref_clk) disable iff (i_rst)
		i_wr ##1 i_rd);
endmodule

// File: verif/test_adc_tail_config_registers.sv
module test_adc_tail_config_registers;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'h0;
	logic i_rst = 1'h1;
	logic [11:0] i_addr = 12'h000;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'h0;
	logic i_rd = 1'h0;
	logic [7:0] o_rdata;
	logic o_hf_trim_enable, o_sync_ref_buffer_powerdown;
	logic o_dc_level_injection_active;
	logic [3:0] o_hf_trim_bits;
	logic [2:0] o_dc_level_injection;
	logic [11:0] o_dc_level_code;
	logic [11:0] adr [5] = '{12'h608, 12'h61d, 12'h70a, 12'h71a, 12'h7ff};
	logic [7:0] msk [5] = '{8'hc0, 8'h82, 8'h01, 8'h0e, 8'h00};
	logic [7:0] m [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [15:0] r = 16'd26531;
	int fails = 0, checks = 0, cyc = 0, k;
	// --------------------------------------------------------------
	// Stimulus and model
	// --------------------------------------------------------------
	atc_regs i_atc_regs (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .o_hf_trim_enable(o_hf_trim_enable),
		.o_hf_trim_bits(o_hf_trim_bits),
		.o_sync_ref_buffer_powerdown(o_sync_ref_buffer_powerdown),
		.o_dc_level_injection_active(o_dc_level_injection_active),
		.o_dc_level_injection(o_dc_level_injection),
		.o_dc_level_code(o_dc_level_code));
	initial forever #25 i_ref_clk = ~i_ref_clk;
	// Guards against a hung strobe loop
	always @(posedge i_ref_clk) begin
		cyc++;
		if (cyc > 4000) begin
			fails++;
			finish_test();
		end
	end
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input string n, input logic [11:0] e, input logic [11:0] s);
		checks++;
		if (s !== e) begin
			fails++;
			$display("wrong value %s exp %h got %h", n, e, s);
		end
	endtask
	// Tasks start right after a rising edge and end right after one
	task wr(input int i, input logic [7:0] d);
		i_addr <= adr[i];
		i_wdata <= d;
		i_wr <= 1'h1;
		@(posedge i_ref_clk);
		i_wr <= 1'h0;
		m[i] = d & msk[i];
	endtask
	task rd(input int i);
		i_addr <= adr[i];
		i_rd <= 1'h1;
		@(posedge i_ref_clk);
		i_rd <= 1'h0;
		@(negedge i_ref_clk);
		chk("rdata", {4'h0, m[i]}, {4'h0, o_rdata});
		@(posedge i_ref_clk);
	endtask
	task outs();
		logic [3:0] t;
		repeat (3) @(negedge i_ref_clk);
		t = {m[0][7:6], m[1][7], m[1][1]};
		chk("trim", {8'h0, t}, {8'h0, o_hf_trim_bits});
		chk("trim_en", {11'h0, t == 4'hf}, {11'h0, o_hf_trim_enable});
		chk("pdn", {11'h0, m[2][0]},
			{11'h0, o_sync_ref_buffer_powerdown});
		chk("dc", {9'h0, m[3][3:1]}, {9'h0, o_dc_level_injection});
		chk("dc_act", {11'h0, m[3][3:1] != 3'h0},
			{11'h0, o_dc_level_injection_active});
		chk("code", 12'(368 * m[3][3:1] + 745), o_dc_level_code);
		@(posedge i_ref_clk);
	endtask
	task finish_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rst <= 1'h0;
		for (k = 0; k < 5; k++) rd(k);
		outs();
		$display("test reset done");
		wr(0, 8'hc0);
		@(posedge i_ref_clk);
		wr(1, 8'h82);
		@(posedge i_ref_clk);
		wr(2, 8'h01);
		outs();
		$display("test trim done");
		for (k = 0; k < 40; k++) begin
			r = nx(r);
			wr(r[10:8] % 5, r[7:0] & msk[r[10:8] % 5]);
			rd(r[10:8] % 5);
			if (k % 8 == 0) outs();
		end
		outs();
		$display("test random done");
		finish_test();
	end
endmodule
